// File: nsp_dt_element.sv
// Purpose: one definite-time element on the negative sequence current
// Assumes: measTick is a one-cycle strobe per measurement cycle
// Notes:   losing active clears timer, pickup and trip at once
`timescale 1ns/1ps
module nsp_dt_element (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                measTick,
  input  wire logic                active,
  input  wire logic [nsp_pkg::CW-1:0] i2Mag,
  input  wire nsp_pkg::nsp_dt_cfg_t cfg,
  output logic                     pickup,
  output logic                     trip
);
  logic [nsp_pkg::TW-1:0] timer_ff;
  logic                   pickup_ff;
  logic                   trip_ff;
  logic                   over;

  assign over   = active && (i2Mag >= cfg.pickup);
  assign pickup = pickup_ff;
  assign trip   = trip_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !over) begin
      timer_ff  <= '0;
      pickup_ff <= 1'b0;
      trip_ff   <= 1'b0;
    end else if (measTick) begin
      pickup_ff <= 1'b1;
      if (timer_ff >= cfg.delay) begin
        trip_ff <= 1'b1;
      end else begin
        timer_ff <= timer_ff + 1'b1;
      end
    end
  end
endmodule

// File: nsp_meas_model.sv
// Purpose: measurement front end feeding the protection block
// Assumes: magnitudes are refreshed only together with the tick
// Notes:   tick spacing is gap+1 cycles, set by the bench at run time
`timescale 1ns/1ps
module nsp_meas_model (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             gap,
  input  wire logic [nsp_pkg::CW-1:0] i2Set,
  input  wire logic [nsp_pkg::CW-1:0] phSet,
  output logic                        measTick,
  output logic      [nsp_pkg::CW-1:0] i2Mag,
  output logic      [nsp_pkg::CW-1:0] phaseA,
  output logic      [nsp_pkg::CW-1:0] phaseB,
  output logic      [nsp_pkg::CW-1:0] phaseC
);
  logic [7:0] cntFf;

  // new magnitudes appear with the tick, stable until the next one
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cntFf    <= 8'h00;
      measTick <= 1'b0;
      i2Mag    <= '0;
      phaseA   <= '0;
      phaseB   <= '0;
      phaseC   <= '0;
    end else if (cntFf >= gap) begin
      cntFf    <= 8'h00;
      measTick <= 1'b1;
      i2Mag    <= i2Set;
      phaseA   <= phSet;
      phaseB   <= phSet;
      phaseC   <= phSet >> 1;
    end else begin
      cntFf    <= cntFf + 8'h01;
      measTick <= 1'b0;
    end
  end
endmodule

// File: nsp_negseq_prot.sv
// Purpose: negative sequence protection with two definite-time elements
//          and one inverse-time element, registers on classic Wishbone
// Assumes: current magnitudes change only with measTick
// Notes:   inverse curve integrates I2 per tick against a trip level
// Overview of operation
// - feed elements only while I2 and phases qualify
// - two definite-time elements: pickup, delay, trip
// - inverse element picks up above 110% setting
// - IEC or ANSI curves; definite elements stay usable
// - IEC drop at 95%, delay cleared at once
// - ANSI without disc drops at once at 95%
// - disc emulation unwinds below 90% at reset rate
// - between 90% and 95% disc time holds
// - below 5% disc emulation ends, time cleared
// - block input inhibits every element
// - failed release clears tripping delay at once
// - function off means no pickup or trip
// - mode selects off, definite only, or both
`timescale 1ns/1ps
module nsp_negseq_prot (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    measTick,
  input  wire logic [nsp_pkg::CW-1:0]  i2Mag,
  input  wire logic [nsp_pkg::CW-1:0]  phaseA,
  input  wire logic [nsp_pkg::CW-1:0]  phaseB,
  input  wire logic [nsp_pkg::CW-1:0]  phaseC,
  input  wire logic                    blockIn,
  output logic      [1:0]              dtPickup,
  output logic      [1:0]              dtTrip,
  output logic                         tocPickup,
  output logic                         tocTrip
);
  logic [31:0] regs_ff [nsp_pkg::NREG];
  logic [31:0] rdData_ff;
  logic        ack_ff;
  logic        wbHit;
  logic [3:0]  wbIdx;
  logic [31:0] statusWord;

  nsp_pkg::nsp_toc_state_t tocState_ff;
  logic [nsp_pkg::AW-1:0]  acc_ff;
  logic                    tocPickup_ff;
  logic                    tocTrip_ff;

  logic        ctrlEn;
  logic [1:0]  ctrlMode;
  logic        discOn;
  logic [31:0] i2x100;
  logic [31:0] nomWord;
  logic [31:0] tocPu;
  logic [31:0] rate;
  logic        relOk;
  logic        funcOn;
  logic        dtActive;
  logic        tocActive;
  logic        over110;
  logic        le95;
  logic        le90;
  logic        lt5;
  logic [nsp_pkg::AW:0] accSum;
  logic [nsp_pkg::AW-1:0] accSat;
  nsp_pkg::nsp_dt_cfg_t dtCfg [2];

  function automatic logic [31:0] pctOf(input logic [31:0] base,
                                        input logic [31:0] pct);
    pctOf = base * pct;
  endfunction

  function automatic logic [31:0] regMask(input logic [3:0] idx);
    unique case (idx)
      nsp_pkg::IDX_CTRL:   regMask = nsp_pkg::MASK_CTRL;
      nsp_pkg::IDX_NOM,
      nsp_pkg::IDX_DT1PU,
      nsp_pkg::IDX_DT2PU,
      nsp_pkg::IDX_TOCPU,
      nsp_pkg::IDX_TOCRST: regMask = nsp_pkg::MASK_CUR;
      nsp_pkg::IDX_TOCLVL: regMask = nsp_pkg::MASK_ACC;
      default:             regMask = nsp_pkg::MASK_TIM;
    endcase
  endfunction

  function automatic logic [31:0] rstVal(input logic [3:0] idx);
    unique case (idx)
      nsp_pkg::IDX_CTRL:   rstVal = nsp_pkg::RST_CTRL;
      nsp_pkg::IDX_NOM:    rstVal = nsp_pkg::RST_NOM;
      nsp_pkg::IDX_DT1PU:  rstVal = nsp_pkg::RST_DT1PU;
      nsp_pkg::IDX_DT1DLY: rstVal = nsp_pkg::RST_DT1DLY;
      nsp_pkg::IDX_DT2PU:  rstVal = nsp_pkg::RST_DT2PU;
      nsp_pkg::IDX_DT2DLY: rstVal = nsp_pkg::RST_DT2DLY;
      nsp_pkg::IDX_TOCPU:  rstVal = nsp_pkg::RST_TOCPU;
      nsp_pkg::IDX_TOCLVL: rstVal = nsp_pkg::RST_TOCLVL;
      nsp_pkg::IDX_TOCRST: rstVal = nsp_pkg::RST_TOCRST;
      default:             rstVal = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      laneMerge[8*b +: 8] = sel[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // wishbone slave, one wait state, ack is a single-cycle pulse
  assign wbIdx = wb_adr_i[5:2];
  assign wbHit = wb_cyc_i && wb_stb_i && !ack_ff && (wb_adr_i[7:6] == 2'h0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // writable settings, one word each, statistics words are read-only
  genvar gi;
  generate
    for (gi = 0; gi < nsp_pkg::NREG; gi++) begin : g_reg
      localparam logic [3:0] IDX = 4'(gi);
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          regs_ff[gi] <= rstVal(IDX);
        end else if (wbHit && wb_we_i && (wbIdx == IDX) &&
                     (IDX < nsp_pkg::IDX_STAT)) begin
          regs_ff[gi] <= laneMerge(regs_ff[gi], wb_dat_i, wb_sel_i)
                         & regMask(IDX);
        end
      end
    end
  endgenerate

  assign statusWord = {20'h0, relOk, blockIn, funcOn, tocState_ff,
                       tocTrip_ff, tocPickup_ff, dtTrip, dtPickup};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_ff <= 32'h0000_0000;
    end else if (wbHit) begin
      if (wbIdx == nsp_pkg::IDX_STAT) begin
        rdData_ff <= statusWord;
      end else if (wbIdx == nsp_pkg::IDX_ACC) begin
        rdData_ff <= acc_ff;
      end else if (wbIdx < nsp_pkg::IDX_STAT) begin
        rdData_ff <= regs_ff[wbIdx];
      end else begin
        rdData_ff <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;

  // settings decode
  assign ctrlEn   = regs_ff[nsp_pkg::IDX_CTRL][nsp_pkg::CTRL_EN];
  assign ctrlMode = regs_ff[nsp_pkg::IDX_CTRL][nsp_pkg::CTRL_MODE +: 2];
  assign discOn   = regs_ff[nsp_pkg::IDX_CTRL][nsp_pkg::CTRL_ANSI] &&
                    regs_ff[nsp_pkg::IDX_CTRL][nsp_pkg::CTRL_DISC];
  assign nomWord  = regs_ff[nsp_pkg::IDX_NOM];
  assign tocPu    = regs_ff[nsp_pkg::IDX_TOCPU];
  assign rate     = regs_ff[nsp_pkg::IDX_TOCRST];
  assign i2x100   = pctOf({16'h0, i2Mag}, nsp_pkg::PCT_BASE);

  // release qualifier on I2 and phase magnitudes
  assign relOk = (i2x100 >= pctOf(nomWord, nsp_pkg::PCT_REL)) &&
                 ({16'h0, phaseA} < pctOf(nomWord, nsp_pkg::MULT_OVER)) &&
                 ({16'h0, phaseB} < pctOf(nomWord, nsp_pkg::MULT_OVER)) &&
                 ({16'h0, phaseC} < pctOf(nomWord, nsp_pkg::MULT_OVER));

  assign funcOn    = ctrlEn && (ctrlMode != nsp_pkg::MODE_OFF) &&
                     !blockIn;
  assign dtActive  = funcOn && relOk;
  assign tocActive = dtActive && (ctrlMode == nsp_pkg::MODE_DTTOC);

  // inverse element thresholds relative to its pickup setting
  assign over110 = i2x100 >  pctOf(tocPu, nsp_pkg::PCT_PICK);
  assign le95    = i2x100 <= pctOf(tocPu, nsp_pkg::PCT_DROP);
  assign le90    = i2x100 <= pctOf(tocPu, nsp_pkg::PCT_UNWIND);
  assign lt5     = i2x100 <  pctOf(tocPu, nsp_pkg::PCT_CLEAR);

  // saturating integration of I2 per tick
  assign accSum = {1'b0, acc_ff} + {17'h0, i2Mag};
  assign accSat = accSum[nsp_pkg::AW] ? '1 : accSum[nsp_pkg::AW-1:0];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_dt
      assign dtCfg[gi].pickup = regs_ff[nsp_pkg::IDX_DT1PU + 4'(2*gi)]
                                [nsp_pkg::CW-1:0];
      assign dtCfg[gi].delay  = regs_ff[nsp_pkg::IDX_DT1DLY + 4'(2*gi)]
                                [nsp_pkg::TW-1:0];
      nsp_dt_element u_dt (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .measTick (measTick),
        .active   (dtActive),
        .i2Mag    (i2Mag),
        .cfg      (dtCfg[gi]),
        .pickup   (dtPickup[gi]),
        .trip     (dtTrip[gi])
      );
    end
  endgenerate

  // inverse-time element state and accumulated time
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !tocActive) begin
      tocState_ff  <= nsp_pkg::TOC_IDLE;
      acc_ff       <= '0;
      tocPickup_ff <= 1'b0;
      tocTrip_ff   <= 1'b0;
    end else if (measTick) begin
      unique case (tocState_ff)
        nsp_pkg::TOC_IDLE: begin
          if (over110) begin
            tocState_ff  <= nsp_pkg::TOC_RUN;
            tocPickup_ff <= 1'b1;
          end
        end
        nsp_pkg::TOC_RUN: begin
          if (le95) begin
            tocPickup_ff <= 1'b0;
            tocTrip_ff   <= 1'b0;
            if (discOn) begin
              tocState_ff <= nsp_pkg::TOC_DISC;
            end else begin
              tocState_ff <= nsp_pkg::TOC_IDLE;
              acc_ff      <= '0;
            end
          end else begin
            acc_ff <= accSat;
            if (accSat >= regs_ff[nsp_pkg::IDX_TOCLVL]) begin
              tocTrip_ff <= 1'b1;
            end
          end
        end
        nsp_pkg::TOC_DISC: begin
          if (over110) begin
            tocState_ff  <= nsp_pkg::TOC_RUN;
            tocPickup_ff <= 1'b1;
          end else if (lt5) begin
            tocState_ff <= nsp_pkg::TOC_IDLE;
            acc_ff      <= '0;
          end else if (le90) begin
            if (acc_ff <= rate) begin
              tocState_ff <= nsp_pkg::TOC_IDLE;
              acc_ff      <= '0;
            end else begin
              acc_ff <= acc_ff - rate;
            end
          end else begin
            acc_ff <= acc_ff;
          end
        end
      endcase
    end
  end

  assign tocPickup = tocPickup_ff;
  assign tocTrip   = tocTrip_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_discEnter;
    tocActive && measTick && tocState_ff == nsp_pkg::TOC_RUN && le95 &&
    discOn;
  endsequence

  property p_release;
    !relOk |=> dtPickup == 2'h0 && !tocPickup && !tocTrip;
  endproperty
  a_release: assert property (p_release)
    else $error("element picked up without release");

  property p_block;
    blockIn |=> dtTrip == 2'h0 && dtPickup == 2'h0 && acc_ff == '0;
  endproperty
  a_block: assert property (p_block)
    else $error("block input did not inhibit");

  property p_off;
    !ctrlEn |=> !(|dtTrip) && !tocTrip && tocState_ff == nsp_pkg::TOC_IDLE;
  endproperty
  a_off: assert property (p_off)
    else $error("function off but element active");

  property p_dtOnly;
    ctrlMode == nsp_pkg::MODE_DT |=> !tocPickup && acc_ff == '0;
  endproperty
  a_dtOnly: assert property (p_dtOnly)
    else $error("inverse element active in definite-only mode");

  property p_tocPick;
    tocActive && measTick && tocState_ff == nsp_pkg::TOC_IDLE && over110
    |=> tocPickup && tocState_ff == nsp_pkg::TOC_RUN;
  endproperty
  a_tocPick: assert property (p_tocPick)
    else $error("inverse element failed to pick up");

  property p_plainDrop;
    tocActive && measTick && tocState_ff == nsp_pkg::TOC_RUN && le95 &&
    !discOn |=> acc_ff == '0 && !tocPickup;
  endproperty
  a_plainDrop: assert property (p_plainDrop)
    else $error("drop out did not clear delay");

  property p_discEnter;
    s_discEnter |=> tocState_ff == nsp_pkg::TOC_DISC && $stable(acc_ff);
  endproperty
  a_discEnter: assert property (p_discEnter)
    else $error("disc emulation not entered");

  property p_hold;
    tocActive && measTick && tocState_ff == nsp_pkg::TOC_DISC && !le90 &&
    !over110 ##1 tocActive |-> $stable(acc_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("disc time moved inside hold band");

  property p_discClear;
    tocActive && measTick && tocState_ff == nsp_pkg::TOC_DISC && lt5 &&
    !over110 |=> acc_ff == '0 && tocState_ff == nsp_pkg::TOC_IDLE;
  endproperty
  a_discClear: assert property (p_discClear)
    else $error("disc emulation not cleared below 5 percent");

  property p_offClear;
    !funcOn |=> acc_ff == '0 && !tocPickup && dtPickup == 2'h0;
  endproperty
  a_offClear: assert property (p_offClear)
    else $error("state not cleared on block or off");
endmodule

// File: nsp_pkg.sv
// Purpose: shared constants and types for negative sequence protection
// Assumes: currents are unsigned magnitudes in one common scale
// Notes:   register indices are word indices, byte address is 4*index
package nsp_pkg;
  localparam int CW = 16;
  localparam int TW = 24;
  localparam int AW = 32;
  localparam int NREG = 11;

  localparam logic [3:0] IDX_CTRL   = 4'h0;
  localparam logic [3:0] IDX_NOM    = 4'h1;
  localparam logic [3:0] IDX_DT1PU  = 4'h2;
  localparam logic [3:0] IDX_DT1DLY = 4'h3;
  localparam logic [3:0] IDX_DT2PU  = 4'h4;
  localparam logic [3:0] IDX_DT2DLY = 4'h5;
  localparam logic [3:0] IDX_TOCPU  = 4'h6;
  localparam logic [3:0] IDX_TOCLVL = 4'h7;
  localparam logic [3:0] IDX_TOCRST = 4'h8;
  localparam logic [3:0] IDX_STAT   = 4'h9;
  localparam logic [3:0] IDX_ACC    = 4'hA;

  localparam int CTRL_EN   = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ANSI = 3;
  localparam int CTRL_DISC = 4;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_DT    = 2'h1;
  localparam logic [1:0] MODE_DTTOC = 2'h2;

  localparam logic [31:0] MASK_CTRL = 32'h0000_001F;
  localparam logic [31:0] MASK_CUR  = 32'h0000_FFFF;
  localparam logic [31:0] MASK_TIM  = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_ACC  = 32'hFFFF_FFFF;

  localparam logic [31:0] RST_CTRL   = 32'h0000_0002;
  localparam logic [31:0] RST_NOM    = 32'h0000_0400;
  localparam logic [31:0] RST_DT1PU  = 32'h0000_0066;
  localparam logic [31:0] RST_DT1DLY = 32'h0000_05DC;
  localparam logic [31:0] RST_DT2PU  = 32'h0000_0200;
  localparam logic [31:0] RST_DT2DLY = 32'h0000_012C;
  localparam logic [31:0] RST_TOCPU  = 32'h0000_0100;
  localparam logic [31:0] RST_TOCLVL = 32'h0010_0000;
  localparam logic [31:0] RST_TOCRST = 32'h0000_0100;

  localparam logic [31:0] PCT_BASE   = 32'h0000_0064;
  localparam logic [31:0] PCT_REL    = 32'h0000_000A;
  localparam logic [31:0] MULT_OVER  = 32'h0000_0004;
  localparam logic [31:0] PCT_PICK   = 32'h0000_006E;
  localparam logic [31:0] PCT_DROP   = 32'h0000_005F;
  localparam logic [31:0] PCT_UNWIND = 32'h0000_005A;
  localparam logic [31:0] PCT_CLEAR  = 32'h0000_0005;

  typedef struct packed {
    logic [CW-1:0] pickup;
    logic [TW-1:0] delay;
  } nsp_dt_cfg_t;

  typedef enum logic [2:0] {
    TOC_IDLE = 3'h1,
    TOC_RUN  = 3'h2,
    TOC_DISC = 3'h4
  } nsp_toc_state_t;
endpackage

// File: test_nsp_negseq_prot.sv
// Purpose: self-checking bench for the negative sequence protection
// Assumes: nominal current programmed to 100, phases A and B at 300, phase C at 150
// Notes:   outputs sampled at the edge after each deciding tick
`timescale 1ns/1ps
module test_nsp_negseq_prot;
  localparam int NOM = 100;
  localparam logic [31:0] RSTV [9] = '{nsp_pkg::RST_CTRL, nsp_pkg::RST_NOM,
    nsp_pkg::RST_DT1PU, nsp_pkg::RST_DT1DLY, nsp_pkg::RST_DT2PU,
    nsp_pkg::RST_DT2DLY, nsp_pkg::RST_TOCPU, nsp_pkg::RST_TOCLVL,
    nsp_pkg::RST_TOCRST};
  localparam logic [15:0] CORNER [6] = '{16'h000A, 16'h0009, 16'h00C8,
    16'h00C7, 16'h01F4, 16'h01F3};
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [7:0]  wbAdr   = 8'h00;
  logic [3:0]  wbSel   = 4'hF;
  logic [31:0] wbDatI  = 32'h0000_0000;
  logic [31:0] wbDatO, rd;
  logic        wbAck, measTick, tocPickup, tocTrip;
  logic        blockIn = 1'b0;
  logic [15:0] i2Mag, phaseA, phaseB, phaseC;
  logic [15:0] i2Set   = 16'h0000;
  logic [15:0] phSet   = 16'h012C;
  logic [7:0]  gap     = 8'h14;
  logic [1:0]  dtPickup, dtTrip;
  logic [31:0] seed    = 32'h5BBC;
  int          miscompares = 0;
  int          totalChecks = 0;
  int          cycles      = 0;

  nsp_meas_model u_meas (.sys_clk(sys_clk), .rst_n(rst_n), .gap(gap),
    .i2Set(i2Set), .phSet(phSet), .measTick(measTick), .i2Mag(i2Mag),
    .phaseA(phaseA), .phaseB(phaseB), .phaseC(phaseC));

  nsp_negseq_prot DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .measTick(measTick), .i2Mag(i2Mag), .phaseA(phaseA), .phaseB(phaseB),
    .phaseC(phaseC), .blockIn(blockIn), .dtPickup(dtPickup),
    .dtTrip(dtTrip), .tocPickup(tocPickup), .tocTrip(tocTrip));

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // definite element pickup: release qualified and at or above setting
  function automatic logic pk(input logic [15:0] i2, pu, ph);
    return (int'(i2) * 100 >= NOM * 10) && (int'(ph) < 4 * NOM)
      && (i2 >= pu);
  endfunction

  function automatic logic [31:0] outv(input logic [1:0] p, t,
                                       input logic tp, tt);
    return {26'h0, p, t, tp, tt};
  endfunction

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge sys_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatI <= d;
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk iff measTick);
    @(posedge sys_clk);
  endtask

  task automatic outs(input logic [31:0] exp);
    check("outputs", outv(dtPickup, dtTrip, tocPickup, tocTrip), exp);
  endtask

  // start a scenario from a disqualified, cleared state
  task automatic restart(input logic [31:0] ctrl, input logic [15:0] i2);
    i2Set <= 16'h0000;
    wb(1'b1, 8'h00, ctrl);
    ticks(1);
    outs(32'h0);
    i2Set <= i2;
  endtask

  task automatic accIs(input logic [31:0] exp);
    wb(1'b0, 8'h28, 32'h0);
    check("accumulated time", rd, exp);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      wb(1'b0, 8'(k * 4), 32'h0);
      check("reset value", rd, RSTV[k]);
    end
    wb(1'b0, 8'h2C, 32'h0);
    check("unmapped read", rd, 32'h0);
    wb(1'b1, 8'h28, 32'hFFFF_FFFF);
    accIs(32'h0);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    wb(1'b0, 8'h00, 32'h0);
    check("control mask", rd, nsp_pkg::MASK_CTRL);
    wbSel <= 4'h1;
    wb(1'b1, 8'h04, 32'hFFFF_FF64);
    wbSel <= 4'hF;
    wb(1'b0, 8'h04, 32'h0);
    check("lane merge", rd, 32'h0000_0464);
    wb(1'b1, 8'h04, 32'h0000_0064);
    wb(1'b1, 8'h08, 32'h0000_00C8);
    wb(1'b1, 8'h0C, 32'h0000_0003);
    wb(1'b1, 8'h10, 32'h0000_01F4);
    wb(1'b1, 8'h14, 32'h0000_0000);
    wb(1'b1, 8'h18, 32'h0000_0100);
    wb(1'b1, 8'h1C, 32'h0000_0708);
    wb(1'b1, 8'h20, 32'h0000_0064);
    // IEC: definite and inverse together
    restart(32'h05, 16'h012C);
    ticks(1);
    outs(outv(2'b01, 2'b00, 1'b1, 1'b0));
    accIs(32'h0);
    ticks(2);
    accIs(32'h258);
    check("dt1 trip early", dtTrip, 2'b00);
    ticks(1);
    check("dt1 trip", dtTrip, 2'b01);
    check("toc not yet", tocTrip, 1'b0);
    ticks(3);
    check("toc trip", tocTrip, 1'b1);
    i2Set <= 16'h00F3;
    ticks(1);
    outs(outv(2'b01, 2'b01, 1'b0, 1'b0));
    accIs(32'h0);
    phSet <= 16'h0190;
    ticks(1);
    outs(32'h0);
    phSet <= 16'h012C;
    // ANSI without disc emulation
    restart(32'h0D, 16'h012C);
    ticks(2);
    check("ansi pickup", tocPickup, 1'b1);
    i2Set <= 16'h00F3;
    ticks(1);
    check("ansi drop", tocPickup, 1'b0);
    accIs(32'h0);
    // ANSI with disc emulation
    restart(32'h1D, 16'h012C);
    ticks(3);
    accIs(32'h258);
    i2Set <= 16'h00F0;
    ticks(1);
    check("disc drop", tocPickup, 1'b0);
    accIs(32'h258);
    ticks(1);
    accIs(32'h258);
    i2Set <= 16'h00C8;
    ticks(1);
    accIs(32'h1F4);
    ticks(1);
    accIs(32'h190);
    i2Set <= 16'h000C;
    ticks(1);
    accIs(32'h0);
    // external block
    restart(32'h05, 16'h012C);
    ticks(1);
    outs(outv(2'b01, 2'b00, 1'b1, 1'b0));
    blockIn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    outs(32'h0);
    ticks(1);
    outs(32'h0);
    wb(1'b0, 8'h24, 32'h0);
    check("status word", rd, 32'h0000_0C40);
    accIs(32'h0);
    blockIn <= 1'b0;
    ticks(1);
    check("timer restarted", dtTrip, 2'b00);
    wb(1'b1, 8'h00, 32'h04);
    ticks(1);
    outs(32'h0);
    wb(1'b1, 8'h00, 32'h03);
    ticks(1);
    outs(outv(2'b01, 2'b00, 1'b0, 1'b0));
    wb(1'b1, 8'h00, 32'h01);
    ticks(1);
    outs(32'h0);
    // definite-only mode, corners then random magnitudes and spacing
    restart(32'h03, 16'h0000);
    for (int k = 0; k < 40; k++) begin
      seed = xs(seed);
      i2Set <= (k < 6) ? CORNER[k] : {6'h00, seed[9:0]};
      phSet <= (seed[20] && k >= 6) ? 16'h0190 : 16'h012C;
      gap   <= 8'h03 + {5'h00, seed[13:11]};
      @(posedge sys_clk);
      ticks(1);
      check("dt pickups", dtPickup, {pk(i2Set, 16'h01F4, phSet),
        pk(i2Set, 16'h00C8, phSet)});
      check("dt2 zero delay", dtTrip[1], pk(i2Set, 16'h01F4, phSet));
    end
    final_report();
  end
endmodule
